// ==== pgrs_regs.svh ====
// timing constants for the power-good reset sequencer
`ifndef PGRS_REGS_SVH
`define PGRS_REGS_SVH
`define PGRS_CLK_HZ 50000000
`define PGRS_T_CLKINT_US 50
`define PGRS_T_INTPG_US 50
`define PGRS_T_NVM_MS 20
`define PGRS_T_TRAIN_MS 20
`define PGRS_T_CFGRES_MS 1000
`define PGRS_T_LPG_MIN_MS 80
`define PGRS_T_LPG_MAX_MS 90
`define PGRS_CYC_PER_US (`PGRS_CLK_HZ / 1000000)
`define PGRS_CYC_PER_MS (`PGRS_CLK_HZ / 1000)
`define PGRS_CYC_INTPG (`PGRS_T_INTPG_US * `PGRS_CYC_PER_US)
`define PGRS_CYC_NVM (`PGRS_T_NVM_MS * `PGRS_CYC_PER_MS)
`define PGRS_CYC_TRAIN (`PGRS_T_TRAIN_MS * `PGRS_CYC_PER_MS)
`define PGRS_CYC_CFGRES (`PGRS_T_CFGRES_MS * `PGRS_CYC_PER_MS)
`define PGRS_CYC_LPG ((`PGRS_T_LPG_MIN_MS + `PGRS_T_LPG_MAX_MS) / 2 * `PGRS_CYC_PER_MS)
`endif

// ==== pgrs_pkg.sv ====
// types for the power-good reset sequencer
package pgrs_pkg;
    typedef enum logic [2:0] {
        PGRS_RAIL_WAIT,
        PGRS_HELD,
        PGRS_PLL_WAIT,
        PGRS_NVM_LOAD,
        PGRS_TRAIN_WAIT,
        PGRS_UNINIT,
        PGRS_ACTIVE
    } pgrs_state_e;
endpackage

// ==== pgrs_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pgrs_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // data
    input wire logic d_in,
    output logic q_out
);
    logic [2:0] sh_r;
    logic [2:0] sh_nxt;
    logic q_r;
    logic q_nxt;
    always_comb begin
        sh_nxt = {sh_r[1:0], d_in};
        q_nxt = (sh_r[2] == sh_r[1]) ? sh_r[2] : q_r;
    end
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sh_r <= 3'h0;
            q_r <= 1'h0;
        end else begin
            sh_r <= sh_nxt;
            q_r <= q_nxt;
        end
    end
    assign q_out = q_r;
endmodule // pgrs_sync

// ==== pgrs_seq.sv ====
// power-good reset sequencer top
// =====================================================================
// Overview of operation
// - power good loss: held state, electrical idle
// - internal clock locked within 50 us
// - internal power good within 50 us
// - internal power good: reload, phy reset, wake off
// - magic packet wake restored from loaded config
// - phy reset released after load, 20 ms max
// - link training starts within 20 ms; if load ends past that, it starts later with timeout set
// - config answer ready within 1 s
// - memory enable write moves to full active
// - local power good 80 to 90 ms after rail
`timescale 1ns/1ps
`include "pgrs_regs.svh"
module pgrs_seq #(
    parameter int unsigned CYC_INTPG = `PGRS_CYC_INTPG,
    parameter int unsigned CYC_NVM = `PGRS_CYC_NVM,
    parameter int unsigned CYC_TRAIN = `PGRS_CYC_TRAIN,
    parameter int unsigned CYC_CFGRES = `PGRS_CYC_CFGRES,
    parameter int unsigned CYC_LPG = `PGRS_CYC_LPG
) (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    // system pins
    input wire logic RAIL_VALID_IN,
    input wire logic POWER_GOOD_INPUT_IN,
    // pll
    input wire logic PLL_LOCK_IN,
    // nonvolatile configuration loader
    input wire logic NVM_DONE_IN,
    input wire logic NVM_WAKE_EN_IN,
    output logic NVM_LOAD_OUT,
    // pci command register write
    input wire logic MEM_ENABLE_WR_IN,
    // controls
    output logic LOCAL_POWER_GOOD_OUT,
    output logic INT_POWER_GOOD_OUT,
    output logic PHY_RESET_OUT,
    output logic ELEC_IDLE_OUT,
    output logic TRAIN_START_OUT,
    output logic CFG_READY_OUT,
    output logic MAGIC_PACKET_WAKE_OUT,
    output logic [2:0] STATE_OUT,
    output logic TIMEOUT_OUT
);
    // =================================================================
    // input synchronisers
    logic rail_s;
    logic pg_s;
    logic lock_s;
    logic nvm_done_s;
    logic [3:0] pin_raw;
    logic [3:0] pin_s;
    assign pin_raw = {NVM_DONE_IN, PLL_LOCK_IN, POWER_GOOD_INPUT_IN, RAIL_VALID_IN};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            pgrs_sync pgrs_sync_inst (
                .clk_in(CLK_IN),
                .reset_in(RESET_IN),
                .d_in(pin_raw[gi]),
                .q_out(pin_s[gi])
            );
        end
    endgenerate
    assign rail_s = pin_s[0];
    assign pg_s = pin_s[1];
    assign lock_s = pin_s[2];
    assign nvm_done_s = pin_s[3];

    // =================================================================
    // state and counters
    pgrs_pkg::pgrs_state_e state_r, state_nxt;
    logic [31:0] lpg_cnt_r, lpg_cnt_nxt;
    logic [31:0] pg_cnt_r, pg_cnt_nxt;
    logic [31:0] st_cnt_r, st_cnt_nxt;
    logic lpg_r, lpg_nxt;
    logic ipg_r, ipg_nxt;
    logic nvm_load_r, nvm_load_nxt;
    logic phy_rst_r, phy_rst_nxt;
    logic idle_r, idle_nxt;
    logic train_r, train_nxt;
    logic cfg_r, cfg_nxt;
    logic wake_r, wake_nxt;
    logic tmo_r, tmo_nxt;

    always_comb begin
        state_nxt = state_r;
        lpg_cnt_nxt = lpg_cnt_r;
        pg_cnt_nxt = pg_cnt_r;
        st_cnt_nxt = st_cnt_r + 32'h1;
        lpg_nxt = lpg_r;
        ipg_nxt = ipg_r;
        nvm_load_nxt = 1'h0;
        phy_rst_nxt = phy_rst_r;
        idle_nxt = idle_r;
        train_nxt = train_r;
        cfg_nxt = cfg_r;
        wake_nxt = wake_r;
        tmo_nxt = tmo_r;
        // local power good from rail
        if (!rail_s) begin
            lpg_cnt_nxt = 32'h0;
            lpg_nxt = 1'h0;
        end else if (lpg_cnt_r >= CYC_LPG - 1) begin
            lpg_nxt = 1'h1;
        end else begin
            lpg_cnt_nxt = lpg_cnt_r + 32'h1;
        end
        // time since power good
        if (pg_s && pg_cnt_r != 32'hffffffff) begin
            pg_cnt_nxt = pg_cnt_r + 32'h1;
        end
        case (state_r)
            pgrs_pkg::PGRS_RAIL_WAIT: begin
                if (lpg_r) begin
                    state_nxt = pgrs_pkg::PGRS_HELD;
                end
            end
            pgrs_pkg::PGRS_HELD: begin
                pg_cnt_nxt = 32'h0;
                st_cnt_nxt = 32'h0;
                if (pg_s) begin
                    state_nxt = pgrs_pkg::PGRS_PLL_WAIT;
                end
            end
            pgrs_pkg::PGRS_PLL_WAIT: begin
                // internal power good on lock, forced early enough to cover sync delay
                if (lock_s || pg_cnt_r >= CYC_INTPG - 6) begin
                    tmo_nxt = tmo_r | !lock_s;
                    ipg_nxt = 1'h1;
                    nvm_load_nxt = 1'h1;
                    phy_rst_nxt = 1'h1;
                    wake_nxt = 1'h0;
                    st_cnt_nxt = 32'h0;
                    state_nxt = pgrs_pkg::PGRS_NVM_LOAD;
                end
            end
            pgrs_pkg::PGRS_NVM_LOAD: begin
                if (nvm_done_s || st_cnt_r >= CYC_NVM - 1) begin
                    tmo_nxt = tmo_r | !nvm_done_s;
                    wake_nxt = nvm_done_s & NVM_WAKE_EN_IN;
                    phy_rst_nxt = 1'h0;
                    state_nxt = pgrs_pkg::PGRS_TRAIN_WAIT;
                end
            end
            pgrs_pkg::PGRS_TRAIN_WAIT: begin
                // training starts right after load; past the bound it still starts, with timeout set
                if (pg_cnt_r < CYC_TRAIN - 1) begin
                    train_nxt = 1'h1;
                    idle_nxt = 1'h0;
                    cfg_nxt = 1'h1;
                    state_nxt = pgrs_pkg::PGRS_UNINIT;
                end else begin
                    tmo_nxt = 1'h1;
                    train_nxt = 1'h1;
                    idle_nxt = 1'h0;
                    cfg_nxt = pg_cnt_r < CYC_CFGRES - 1;
                    state_nxt = pgrs_pkg::PGRS_UNINIT;
                end
            end
            pgrs_pkg::PGRS_UNINIT: begin
                if (MEM_ENABLE_WR_IN) begin
                    state_nxt = pgrs_pkg::PGRS_ACTIVE;
                end
            end
            pgrs_pkg::PGRS_ACTIVE: begin
            end
            default: begin
                state_nxt = pgrs_pkg::PGRS_RAIL_WAIT;
            end
        endcase
        // loss of power good or rail overrides all
        if (!pg_s && state_r != pgrs_pkg::PGRS_RAIL_WAIT) begin
            state_nxt = pgrs_pkg::PGRS_HELD;
            ipg_nxt = 1'h0;
            phy_rst_nxt = 1'h1;
            idle_nxt = 1'h1;
            train_nxt = 1'h0;
            cfg_nxt = 1'h0;
            nvm_load_nxt = 1'h0;
        end
        if (!lpg_r) begin
            state_nxt = pgrs_pkg::PGRS_RAIL_WAIT;
            ipg_nxt = 1'h0;
            phy_rst_nxt = 1'h1;
            idle_nxt = 1'h1;
            train_nxt = 1'h0;
            cfg_nxt = 1'h0;
            nvm_load_nxt = 1'h0;
        end
    end

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_r <= pgrs_pkg::PGRS_RAIL_WAIT;
            lpg_cnt_r <= 32'h0;
            pg_cnt_r <= 32'h0;
            st_cnt_r <= 32'h0;
            lpg_r <= 1'h0;
            ipg_r <= 1'h0;
            nvm_load_r <= 1'h0;
            phy_rst_r <= 1'h1;
            idle_r <= 1'h1;
            train_r <= 1'h0;
            cfg_r <= 1'h0;
            wake_r <= 1'h0;
            tmo_r <= 1'h0;
        end else begin
            state_r <= state_nxt;
            lpg_cnt_r <= lpg_cnt_nxt;
            pg_cnt_r <= pg_cnt_nxt;
            st_cnt_r <= st_cnt_nxt;
            lpg_r <= lpg_nxt;
            ipg_r <= ipg_nxt;
            nvm_load_r <= nvm_load_nxt;
            phy_rst_r <= phy_rst_nxt;
            idle_r <= idle_nxt;
            train_r <= train_nxt;
            cfg_r <= cfg_nxt;
            wake_r <= wake_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    // =================================================================
    // outputs
    logic [2:0] state_out_r;
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_out_r <= 3'h0;
        end else begin
            state_out_r <= state_nxt;
        end
    end
    assign STATE_OUT = state_out_r;
    assign LOCAL_POWER_GOOD_OUT = lpg_r;
    assign INT_POWER_GOOD_OUT = ipg_r;
    assign NVM_LOAD_OUT = nvm_load_r;
    assign PHY_RESET_OUT = phy_rst_r;
    assign ELEC_IDLE_OUT = idle_r;
    assign TRAIN_START_OUT = train_r;
    assign CFG_READY_OUT = cfg_r;
    assign MAGIC_PACKET_WAKE_OUT = wake_r;
    assign TIMEOUT_OUT = tmo_r;
endmodule // pgrs_seq

// ==== pgrs_host_model.sv ====
// host-side model of pll lock and configuration memory
`timescale 1ns/1ps
module pgrs_host_model (
    // clock and power good
    input wire logic clk_in,
    input wire logic pg_in,
    // load request and stored wake value
    input wire logic load_in,
    input wire logic wake_in,
    input wire logic [15:0] lock_dly_in,
    input wire logic [15:0] nvm_dly_in,
    // answers
    output logic lock_out = 1'b0,
    output logic done_out = 1'b0,
    output logic wake_en_out
);
    logic [15:0] lcnt = 16'h0;
    logic [15:0] ncnt = 16'h0;
    logic busy = 1'b0;
    // delay zero means never answers
    always @(posedge clk_in) begin
        lcnt <= pg_in ? lcnt + 16'h1 : 16'h0;
        lock_out <= pg_in && lock_dly_in != 16'h0 && lcnt >= lock_dly_in;
        busy <= pg_in && (busy || load_in);
        ncnt <= busy ? ncnt + 16'h1 : 16'h0;
        done_out <= busy && nvm_dly_in != 16'h0 && ncnt >= nvm_dly_in;
    end
    // stale value inverted while no load is complete
    assign wake_en_out = done_out ? wake_in : ~wake_in;
endmodule // pgrs_host_model

// ==== pgrs_seq_assertions.sv ====
// assertions for the power-good reset sequencer
`timescale 1ns/1ps
module pgrs_seq_chk #(
    parameter int unsigned CYC_INTPG = 20,
    parameter int unsigned CYC_TRAIN = 400,
    parameter int unsigned CYC_CFGRES = 900,
    parameter int unsigned CYC_LPG = 50
) (
    // watched ports
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic RAIL_VALID_IN,
    input wire logic POWER_GOOD_INPUT_IN,
    input wire logic NVM_DONE_IN,
    input wire logic MEM_ENABLE_WR_IN,
    input wire logic NVM_LOAD_OUT,
    input wire logic LOCAL_POWER_GOOD_OUT,
    input wire logic INT_POWER_GOOD_OUT,
    input wire logic PHY_RESET_OUT,
    input wire logic ELEC_IDLE_OUT,
    input wire logic TRAIN_START_OUT,
    input wire logic CFG_READY_OUT,
    input wire logic MAGIC_PACKET_WAKE_OUT,
    input wire logic [2:0] STATE_OUT,
    input wire logic TIMEOUT_OUT
);
    localparam int LIM_PG = CYC_INTPG;
    localparam int LIM_TR = CYC_TRAIN + 8;
    localparam int LIM_CFG = CYC_CFGRES + 8;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // ==========================================
    // checks
    idle_on_loss_a: assert property ($fell(POWER_GOOD_INPUT_IN) && STATE_OUT > 3'h1 |->
        ##[1:8] STATE_OUT == 3'h1 && ELEC_IDLE_OUT && PHY_RESET_OUT && !INT_POWER_GOOD_OUT) else $error("no idle");
    int_pg_bound_a: assert property ($rose(POWER_GOOD_INPUT_IN) && STATE_OUT == 3'h1 |->
        ##[1:LIM_PG] INT_POWER_GOOD_OUT) else $error("internal power good late");
    load_start_a: assert property ($rose(INT_POWER_GOOD_OUT) |-> ##[0:1] NVM_LOAD_OUT) else $error("no load");
    load_pulse_a: assert property (NVM_LOAD_OUT |=> !NVM_LOAD_OUT && PHY_RESET_OUT && !MAGIC_PACKET_WAKE_OUT)
        else $error("load pulse wrong");
    phy_after_load_a: assert property ($fell(PHY_RESET_OUT) |-> NVM_DONE_IN || TIMEOUT_OUT)
        else $error("phy released early");
    train_bound_a: assert property ($rose(POWER_GOOD_INPUT_IN) && STATE_OUT == 3'h1 |->
        ##[1:LIM_TR] TRAIN_START_OUT) else $error("training late");
    cfg_bound_a: assert property ($rose(POWER_GOOD_INPUT_IN) && STATE_OUT == 3'h1 |->
        ##[1:LIM_CFG] CFG_READY_OUT && !ELEC_IDLE_OUT && STATE_OUT == 3'h5) else $error("config late");
    mem_enable_a: assert property (MEM_ENABLE_WR_IN && STATE_OUT == 3'h5 |=> STATE_OUT == 3'h6)
        else $error("no full active");
    refuse_early_a: assert property (MEM_ENABLE_WR_IN && STATE_OUT < 3'h5 |=> STATE_OUT != 3'h6)
        else $error("early active");
    local_pg_a: assert property ($rose(LOCAL_POWER_GOOD_OUT) |-> $past(RAIL_VALID_IN, CYC_LPG))
        else $error("local power good early");
endmodule // pgrs_seq_chk
bind pgrs_seq pgrs_seq_chk #(.CYC_INTPG(CYC_INTPG), .CYC_TRAIN(CYC_TRAIN), .CYC_CFGRES(CYC_CFGRES), .CYC_LPG(CYC_LPG))
    pgrs_seq_chk_inst (.CLK_IN, .RESET_IN, .RAIL_VALID_IN, .POWER_GOOD_INPUT_IN, .NVM_DONE_IN, .MEM_ENABLE_WR_IN,
    .NVM_LOAD_OUT, .LOCAL_POWER_GOOD_OUT, .INT_POWER_GOOD_OUT, .PHY_RESET_OUT, .ELEC_IDLE_OUT, .TRAIN_START_OUT,
    .CFG_READY_OUT, .MAGIC_PACKET_WAKE_OUT, .STATE_OUT, .TIMEOUT_OUT);

// ==== tb.sv ====
// testbench for the power-good reset sequencer
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rail = 1'b0;
    logic pg = 1'b0;
    logic wr = 1'b0;
    logic wake = 1'b0;
    logic [15:0] ld = 16'h0;
    logic [15:0] nd = 16'h0;
    logic lock, done, wen, load, lpg, ipg, phy, idle, trn, cfg, mpw, tmo;
    logic [2:0] st;
    int err_count = 0;
    int n_tests = 0;
    int c;
    always #10 clk = ~clk;
    pgrs_host_model pgrs_host_model_inst (.clk_in(clk), .pg_in(pg), .load_in(load), .wake_in(wake),
        .lock_dly_in(ld), .nvm_dly_in(nd), .lock_out(lock), .done_out(done), .wake_en_out(wen));
    pgrs_seq #(.CYC_INTPG(20), .CYC_NVM(200), .CYC_TRAIN(400), .CYC_CFGRES(900), .CYC_LPG(50)) pgrs_seq_inst (
        .CLK_IN(clk), .RESET_IN(rst), .RAIL_VALID_IN(rail), .POWER_GOOD_INPUT_IN(pg), .PLL_LOCK_IN(lock),
        .NVM_DONE_IN(done), .NVM_WAKE_EN_IN(wen), .NVM_LOAD_OUT(load), .MEM_ENABLE_WR_IN(wr),
        .LOCAL_POWER_GOOD_OUT(lpg), .INT_POWER_GOOD_OUT(ipg), .PHY_RESET_OUT(phy), .ELEC_IDLE_OUT(idle),
        .TRAIN_START_OUT(trn), .CFG_READY_OUT(cfg), .MAGIC_PACKET_WAKE_OUT(mpw), .STATE_OUT(st), .TIMEOUT_OUT(tmo));
    task results;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wt(input logic [2:0] s);
        for (c = 0; c < 2000 && st !== s; c++) @(posedge clk);
        if (st !== s) begin
            err_count++;
            results();
        end
    endtask
    // ==========================================
    // scenarios
    task t_rail;
        chk({phy, idle, ipg, trn, cfg, load, lpg, tmo}, 8'hc0);
        chk({mpw, 4'h0, st}, 8'h0);
        rail <= 1'b1;
        @(posedge clk);
        wt(3'h1);
        chk({7'h0, c >= 49 && c <= 56}, 8'h1);
        chk({7'h0, lpg}, 8'h1);
        $display("rail test done");
    endtask
    task t_boot(input logic w, input logic [15:0] l, input logic [15:0] n, input logic to);
        wake <= w;
        ld <= l;
        nd <= n;
        repeat (20) @(posedge clk);
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
        chk({5'h0, st}, 8'h1);
        pg <= 1'b1;
        @(posedge clk);
        wt(3'h3);
        chk({7'h0, c <= 20}, 8'h1);
        chk({ipg, phy, mpw, load}, 4'hd);
        wt(3'h5);
        chk({phy, trn, cfg, idle, mpw, tmo}, {4'h6, w & ~to, to});
        $display("boot test done");
    endtask
    task t_active;
        repeat (10) @(posedge clk);
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        repeat (2) @(posedge clk);
        chk({5'h0, st}, 8'h6);
        $display("active test done");
    endtask
    task t_drop(input logic w);
        pg <= 1'b0;
        @(posedge clk);
        wt(3'h1);
        chk({idle, phy, ipg, trn, cfg, mpw}, {4'hc, 1'b0, w});
        $display("drop test done");
    endtask
    task t_loss;
        rail <= 1'b0;
        @(posedge clk);
        wt(3'h0);
        chk({phy, idle, ipg, trn, cfg, load, lpg, tmo}, 8'hc0);
        $display("rail loss test done");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_rail();
        t_boot(1'b1, 16'h5, 16'h1e, 1'b0);
        t_active();
        t_drop(1'b1);
        t_boot(1'b0, 16'hc, 16'h96, 1'b0);
        t_drop(1'b0);
        t_boot(1'b1, 16'h0, 16'h0, 1'b1);
        rst <= 1'b1;
        rail <= 1'b0;
        pg <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_rail();
        t_boot(1'b1, 16'h3, 16'ha, 1'b0);
        t_loss();
        results();
    end
endmodule // tb
